// >>> verilog/ascp_core.sv
`timescale 1ns/1ns
// Overview of operation
// - mode bit 6 clear gives eight data bits, set gives seven.
// - without multiprocessor format, mode bit 5 adds one parity bit after data.
// - mode bit 3 selects one or two stop bits in every format.
// - sixteen formats; multiprocessor flag takes the parity slot, parity enable ignored.
// - frame is low start, data lsb first, optional parity or flag, high stops.
// - line idles high; a fall to low starts a character.
// - receiver aligns bit timing on each start bit falling edge.
// - receiver samples at sixteen times bit rate, latching on eighth pulse.
// - transmit and receive paths run independently, full duplex.
// - each direction has a holding and a shift register for back-to-back characters.
// - receiver flags framing, parity, overrun errors and line break separately.
// - all bit timing comes from the internal baud generator only.
// - clearing transmit enable sets buffer empty and resets transmit shifter.
// - clearing receive enable keeps buffer full, error flags and receive buffer.
// - baud generator divides its input by divisor plus one.
// - prescale select picks system clock divided by 1, 4, 16 or 64.
// - with two stop bits only the first is checked for framing.
// - character completing while buffer full raises overrun and is not stored.
module ascp_core (
   input wire logic clk,
   input wire logic rst_b,
   input wire ascp_pkg::ascp_wb_req_t wb_req,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rxd,
   output logic txd
);
   import ascp_pkg::*;

   typedef struct packed {
      logic rx_s1;
      logic rx_s2;
      logic rx_prev;
      logic [6:0] pre_cnt;
      logic [7:0] brg_cnt;
      logic half;
      logic tick;
      logic [7:0] mode;
      logic [7:0] divisor;
      logic [7:0] ctrl;
      logic [7:0] tx_hold;
      logic [7:0] rx_buf;
      logic tx_buffer_empty;
      logic tend;
      logic rx_buffer_full;
      logic overrun_err_flag;
      logic framing_err_flag;
      logic parity_err_flag;
      logic mpb_rx;
      ascp_bit_st_t tx_st;
      logic [3:0] tx_sub;
      logic [2:0] tx_idx;
      logic [7:0] tx_shift;
      logic tx_mpb;
      logic tx_stop2;
      logic txd;
      ascp_bit_st_t rx_st;
      logic [3:0] rx_sub;
      logic [2:0] rx_idx;
      logic [7:0] rx_shift;
      logic rx_parbit;
      logic ack;
      logic [31:0] dat;
   } ascp_state_t;

   localparam ascp_state_t ASCP_STATE_RST = '{
      rx_s1: 1'b1, rx_s2: 1'b1, rx_prev: 1'b1, pre_cnt: 7'h00, brg_cnt: 8'h00, half: 1'b0,
      tick: 1'b0, mode: ASCP_MODE_RST, divisor: ASCP_DIV_RST, ctrl: ASCP_CTRL_RST,
      tx_hold: 8'h00, rx_buf: 8'h00, tx_buffer_empty: 1'b1, tend: 1'b1, rx_buffer_full: 1'b0, overrun_err_flag: 1'b0,
      framing_err_flag: 1'b0, parity_err_flag: 1'b0, mpb_rx: 1'b0, tx_st: ASCP_IDLE, tx_sub: 4'h0, tx_idx: 3'h0,
      tx_shift: 8'h00, tx_mpb: 1'b0, tx_stop2: 1'b0, txd: 1'b1, rx_st: ASCP_IDLE,
      rx_sub: 4'h0, rx_idx: 3'h0, rx_shift: 8'h00, rx_parbit: 1'b0, ack: 1'b0, dat: 32'h0};

   ascp_state_t s_reg;
   ascp_state_t s_next;

   // prescaler terminal count for the selected input clock
   function automatic logic [6:0] pre_limit(input logic [1:0] sel);
      if (sel == 2'b00) begin
         return ASCP_PRE_DIV1;
      end else if (sel == 2'b01) begin
         return ASCP_PRE_DIV4;
      end else if (sel == 2'b10) begin
         return ASCP_PRE_DIV16;
      end else begin
         return ASCP_PRE_DIV64;
      end
   endfunction

   // data bits of a character, masked to the selected length
   function automatic logic [7:0] char_data(input logic [7:0] d, input logic chr7);
      return chr7 ? (d & 8'h7f) : d;
   endfunction

   logic chr7;
   logic par_slot;
   logic [2:0] last_idx;
   logic wr_cyc;
   logic err_any;
   logic rx_fall;

   assign chr7 = s_reg.mode[ASCP_MODE_CHR];
   // parity slot present when multiprocessor or parity enabled
   assign par_slot = s_reg.mode[ASCP_MODE_MP] | s_reg.mode[ASCP_MODE_PE];
   assign last_idx = chr7 ? 3'h6 : 3'h7;
   // write takes effect at the edge where the master sees ack
   assign wr_cyc = wb_req.cyc & wb_req.stb & wb_req.we & s_reg.ack & wb_req.sel[0];
   assign err_any = s_reg.overrun_err_flag | s_reg.framing_err_flag | s_reg.parity_err_flag;
   // start edge on the synchronised line only
   assign rx_fall = s_reg.rx_prev & ~s_reg.rx_s2;

   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      s_next.rx_s1 = rxd;
      s_next.rx_s2 = s_reg.rx_s1;
      s_next.rx_prev = s_reg.rx_s2;

      if (s_reg.pre_cnt >= pre_limit({s_reg.mode[ASCP_MODE_CKS_HI], s_reg.mode[ASCP_MODE_CKS_LO]})) begin
         s_next.pre_cnt = 7'h00;
         // divide by divisor plus one, then by two for the 16x tick
         if (s_reg.brg_cnt >= s_reg.divisor) begin
            s_next.brg_cnt = 8'h00;
            s_next.half = ~s_reg.half;
            s_next.tick = s_reg.half;
         end else begin
            s_next.brg_cnt = s_reg.brg_cnt + 8'h01;
         end
      end else begin
         s_next.pre_cnt = s_reg.pre_cnt + 7'h01;
      end
      // bus side: answer one cycle after the request, drop ack after one cycle
      s_next.ack = wb_req.cyc & wb_req.stb & ~s_reg.ack;
      if (wb_req.cyc & wb_req.stb & ~s_reg.ack) begin
         if (wb_req.adr == ASCP_OFS_MODE) begin
            s_next.dat = {24'h0, s_reg.mode};
         end else if (wb_req.adr == ASCP_OFS_DIV) begin
            s_next.dat = {24'h0, s_reg.divisor};
         end else if (wb_req.adr == ASCP_OFS_CTRL) begin
            s_next.dat = {24'h0, s_reg.ctrl};
         end else if (wb_req.adr == ASCP_OFS_TXDATA) begin
            s_next.dat = {24'h0, s_reg.tx_hold};
         end else if (wb_req.adr == ASCP_OFS_STATUS) begin
            // break shows while framing error stands and line is low
            s_next.dat = {24'h0, s_reg.tx_buffer_empty, s_reg.rx_buffer_full, s_reg.overrun_err_flag, s_reg.framing_err_flag, s_reg.parity_err_flag,
                          s_reg.tend, s_reg.mpb_rx, s_reg.framing_err_flag & ~s_reg.rx_s2};
         end else if (wb_req.adr == ASCP_OFS_RXDATA) begin
            s_next.dat = {24'h0, s_reg.rx_buf};
         end else begin
            s_next.dat = 32'h0;
         end
      end
      // clears come first so that a hardware set in the same cycle wins
      if (wr_cyc) begin
         if (wb_req.adr == ASCP_OFS_MODE) begin
            s_next.mode = wb_req.dat[7:0];
         end else if (wb_req.adr == ASCP_OFS_DIV) begin
            s_next.divisor = wb_req.dat[7:0];
         end else if (wb_req.adr == ASCP_OFS_CTRL) begin
            s_next.ctrl = wb_req.dat[7:0];
         end else if (wb_req.adr == ASCP_OFS_TXDATA) begin
            s_next.tx_hold = wb_req.dat[7:0];
            s_next.tx_buffer_empty = 1'b0;
            s_next.tend = 1'b0;
         end else if (wb_req.adr == ASCP_OFS_STATUS) begin
            s_next.rx_buffer_full = s_reg.rx_buffer_full & wb_req.dat[ASCP_ST_RX_BUFFER_FULL];
            s_next.overrun_err_flag = s_reg.overrun_err_flag & wb_req.dat[ASCP_ST_OVERRUN_ERR_FLAG];
            s_next.framing_err_flag = s_reg.framing_err_flag & wb_req.dat[ASCP_ST_FER];
            s_next.parity_err_flag = s_reg.parity_err_flag & wb_req.dat[ASCP_ST_PER];
         end
      end
      // transmitter runs on its own state
      if (!s_reg.ctrl[ASCP_CTRL_TE]) begin
         // disabled transmitter: buffer empty, shifter reset
         s_next.tx_st = ASCP_IDLE;
         s_next.tx_buffer_empty = 1'b1;
         s_next.tx_shift = 8'h00;
         s_next.tx_sub = 4'h0;
      end else if (s_reg.tx_st == ASCP_IDLE) begin
         if (!s_next.tx_buffer_empty) begin
            // holding register moves to the shifter
            s_next.tx_shift = s_next.tx_hold;
            s_next.tx_mpb = s_reg.ctrl[ASCP_CTRL_MPBT];
            s_next.tx_buffer_empty = 1'b1;
            s_next.tx_st = ASCP_START;
            s_next.tx_sub = 4'h0;
         end
      end else if (s_reg.tick) begin
         s_next.tx_sub = s_reg.tx_sub + 4'h1;
         if (s_reg.tx_sub == ASCP_SUB_LAST) begin
            case (s_reg.tx_st)
               ASCP_START: begin
                  s_next.tx_st = ASCP_DATA;
                  s_next.tx_idx = 3'h0;
               end
               ASCP_DATA: begin
                  if (s_reg.tx_idx == last_idx) begin
                     s_next.tx_st = par_slot ? ASCP_PAR : ASCP_STOP;
                     s_next.tx_stop2 = 1'b0;
                  end else begin
                     s_next.tx_idx = s_reg.tx_idx + 3'h1;
                  end
               end
               ASCP_PAR: begin
                  s_next.tx_st = ASCP_STOP;
                  s_next.tx_stop2 = 1'b0;
               end
               default: begin
                  if (s_reg.mode[ASCP_MODE_STOP] && !s_reg.tx_stop2) begin
                     s_next.tx_stop2 = 1'b1;
                  end else if (!s_next.tx_buffer_empty) begin
                     s_next.tx_shift = s_next.tx_hold;
                     s_next.tx_mpb = s_reg.ctrl[ASCP_CTRL_MPBT];
                     s_next.tx_buffer_empty = 1'b1;
                     s_next.tx_st = ASCP_START;
                  end else begin
                     s_next.tx_st = ASCP_IDLE;
                     s_next.tend = 1'b1;
                  end
               end
            endcase
         end
      end
      // line level from the transmit state
      case (s_next.tx_st)
         ASCP_START: s_next.txd = 1'b0;
         ASCP_DATA: s_next.txd = s_next.tx_shift[s_next.tx_idx];
         // flag bit replaces parity; polarity over data bits only
         ASCP_PAR: s_next.txd = s_reg.mode[ASCP_MODE_MP] ? s_next.tx_mpb :
                                (^char_data(s_next.tx_shift, chr7)) ^ s_reg.mode[ASCP_MODE_ODD];
         default: s_next.txd = 1'b1;
      endcase
      // receiver; disabling touches no flag or buffer
      if (!s_reg.ctrl[ASCP_CTRL_RE]) begin
         s_next.rx_st = ASCP_IDLE;
      end else if (s_reg.rx_st == ASCP_IDLE) begin
         // a stuck error flag holds the receiver off until cleared
         if (rx_fall && !err_any) begin
            s_next.rx_st = ASCP_START;
            s_next.rx_sub = 4'h0;
            s_next.rx_shift = 8'h00;
         end
      end else if (s_reg.tick) begin
         s_next.rx_sub = s_reg.rx_sub + 4'h1;
         case (s_reg.rx_st)
            ASCP_START: begin
               // eighth pulse; a short glitch is not a start bit
               if (s_reg.rx_sub == ASCP_SUB_SAMPLE && s_reg.rx_s2) begin
                  s_next.rx_st = ASCP_IDLE;
               end else if (s_reg.rx_sub == ASCP_SUB_LAST) begin
                  s_next.rx_st = ASCP_DATA;
                  s_next.rx_idx = 3'h0;
               end
            end
            ASCP_DATA: begin
               if (s_reg.rx_sub == ASCP_SUB_SAMPLE) begin
                  s_next.rx_shift[s_reg.rx_idx] = s_reg.rx_s2;
               end else if (s_reg.rx_sub == ASCP_SUB_LAST) begin
                  if (s_reg.rx_idx == last_idx) begin
                     s_next.rx_st = par_slot ? ASCP_PAR : ASCP_STOP;
                  end else begin
                     s_next.rx_idx = s_reg.rx_idx + 3'h1;
                  end
               end
            end
            ASCP_PAR: begin
               if (s_reg.rx_sub == ASCP_SUB_SAMPLE) begin
                  s_next.rx_parbit = s_reg.rx_s2;
               end else if (s_reg.rx_sub == ASCP_SUB_LAST) begin
                  s_next.rx_st = ASCP_STOP;
               end
            end
            default: begin
               // only the first stop bit is checked
               if (s_reg.rx_sub == ASCP_SUB_SAMPLE) begin
                  s_next.rx_st = ASCP_IDLE;
                  if (s_reg.rx_buffer_full) begin
                     s_next.overrun_err_flag = 1'b1;
                  end else begin
                     s_next.rx_buf = char_data(s_reg.rx_shift, chr7);
                     s_next.rx_buffer_full = 1'b1;
                     s_next.framing_err_flag = s_next.framing_err_flag | ~s_reg.rx_s2;
                     s_next.parity_err_flag = s_next.parity_err_flag | (s_reg.mode[ASCP_MODE_PE] & ~s_reg.mode[ASCP_MODE_MP] &
                        (s_reg.rx_parbit != ((^char_data(s_reg.rx_shift, chr7)) ^ s_reg.mode[ASCP_MODE_ODD])));
                     s_next.mpb_rx = s_reg.mode[ASCP_MODE_MP] & s_reg.rx_parbit;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= ASCP_STATE_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wb_dat_o = s_reg.dat;
   assign wb_ack_o = s_reg.ack;
   assign txd = s_reg.txd;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_tx_idle_mark: assert property (s_reg.tx_st == ASCP_IDLE |-> txd)
      else $error("line not marking while transmitter idle");
   a_tx_start_low: assert property ($rose(s_reg.tx_st == ASCP_START) |-> !txd)
      else $error("start bit not low");
   a_tx_stop_high: assert property (s_reg.tx_st == ASCP_STOP |-> txd)
      else $error("stop bit not high");
   a_tx_par_slot: assert property (s_reg.tx_st == ASCP_PAR |-> par_slot)
      else $error("parity slot sent while disabled");
   a_te_clear_empty: assert property ($fell(s_reg.ctrl[ASCP_CTRL_TE]) |=> s_reg.tx_buffer_empty && s_reg.tx_st == ASCP_IDLE)
      else $error("transmit disable did not empty buffer");
   a_re_clear_keep: assert property ($fell(s_reg.ctrl[ASCP_CTRL_RE]) |-> $stable(s_reg.rx_buf))
      else $error("receive disable changed buffer");
   a_rx_start_edge: assert property ($rose(s_reg.rx_st == ASCP_START) |-> $past(rx_fall))
      else $error("receiver started without falling edge");
   a_overrun_hold: assert property (s_reg.rx_st == ASCP_STOP && s_reg.tick && s_reg.rx_sub == ASCP_SUB_SAMPLE
      && s_reg.rx_buffer_full && s_reg.ctrl[ASCP_CTRL_RE] |=> s_reg.overrun_err_flag && $stable(s_reg.rx_buf))
      else $error("overrun not flagged or buffer overwritten");
   a_tick_spacing: assert property (s_reg.tick |=> !s_reg.tick)
      else $error("sample ticks back to back");
endmodule

// >>> verilog/ascp_pkg.sv
package ascp_pkg;
   // register byte offsets on the wishbone bus
   localparam logic [7:0] ASCP_OFS_MODE = 8'h00;
   localparam logic [7:0] ASCP_OFS_DIV = 8'h04;
   localparam logic [7:0] ASCP_OFS_CTRL = 8'h08;
   localparam logic [7:0] ASCP_OFS_TXDATA = 8'h0c;
   localparam logic [7:0] ASCP_OFS_STATUS = 8'h10;
   localparam logic [7:0] ASCP_OFS_RXDATA = 8'h14;
   // serial_frame_mode fields
   localparam int ASCP_MODE_CHR = 6;
   localparam int ASCP_MODE_PE = 5;
   localparam int ASCP_MODE_ODD = 4;
   localparam int ASCP_MODE_STOP = 3;
   localparam int ASCP_MODE_MP = 2;
   localparam int ASCP_MODE_CKS_HI = 1;
   localparam int ASCP_MODE_CKS_LO = 0;
   // serial_ctrl_reg fields
   localparam int ASCP_CTRL_TE = 5;
   localparam int ASCP_CTRL_RE = 4;
   localparam int ASCP_CTRL_MPBT = 0;
   // serial_status_reg fields
   localparam int ASCP_ST_TX_BUFFER_EMPTY = 7;
   localparam int ASCP_ST_RX_BUFFER_FULL = 6;
   localparam int ASCP_ST_OVERRUN_ERR_FLAG = 5;
   localparam int ASCP_ST_FER = 4;
   localparam int ASCP_ST_PER = 3;
   localparam int ASCP_ST_TEND = 2;
   localparam int ASCP_ST_MPB = 1;
   localparam int ASCP_ST_BRK = 0;
   // reset values
   localparam logic [7:0] ASCP_MODE_RST = 8'h00;
   localparam logic [7:0] ASCP_DIV_RST = 8'hff;
   localparam logic [7:0] ASCP_CTRL_RST = 8'h00;
   // 16 sample ticks per bit, sample on the eighth
   localparam logic [3:0] ASCP_SUB_SAMPLE = 4'h7;
   localparam logic [3:0] ASCP_SUB_LAST = 4'hf;
   localparam logic [6:0] ASCP_PRE_DIV1 = 7'h00;
   localparam logic [6:0] ASCP_PRE_DIV4 = 7'h03;
   localparam logic [6:0] ASCP_PRE_DIV16 = 7'h0f;
   localparam logic [6:0] ASCP_PRE_DIV64 = 7'h3f;

   typedef enum logic [2:0] {
      ASCP_IDLE = 3'b000,
      ASCP_START = 3'b001,
      ASCP_DATA = 3'b010,
      ASCP_PAR = 3'b011,
      ASCP_STOP = 3'b100
   } ascp_bit_st_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } ascp_wb_req_t;
endpackage

// >>> testbench/ascp_peer.sv
`timescale 1ns/1ns
module ascp_peer (
   input wire logic clk,
   input wire logic line_in,
   output logic line_out
);
   int bit_clks = 32;
   int nbits = 8;
   logic has_extra = 1'b0;
   int stops = 1;
   int cyc = 0;
   int start_at = 0;
   int last_gap = 0;
   logic [9:0] q[$];
   logic [7:0] sh;
   logic ex;
   logic ok;

   initial begin
      line_out = 1'b1;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
   end

   always begin
      @(negedge line_in);
      last_gap = cyc - start_at;
      start_at = cyc;
      sh = 8'h00;
      ex = 1'b0;
      repeat (bit_clks / 2) @(posedge clk);
      // a start bit that is gone by mid-bit marks the frame bad
      ok = ~line_in;
      for (int i = 0; i < nbits + has_extra + stops; i++) begin
         repeat (bit_clks) @(posedge clk);
         if (i < nbits) begin
            sh[i] = line_in;
         end else if (has_extra && i == nbits) begin
            ex = line_in;
         end else begin
            ok = ok & line_in;
         end
      end
      q.push_back({ok, ex, sh});
   end

   task automatic send(input logic [7:0] d, input logic xb, input logic sb, input logic brk);
      @(posedge clk);
      line_out <= 1'b0;
      for (int i = 0; i < nbits + has_extra + stops; i++) begin
         repeat (bit_clks) @(posedge clk);
         line_out <= (i < nbits) ? d[i] : (has_extra && i == nbits) ? xb : (i == nbits + has_extra) ? sb : 1'b1;
      end
      repeat (bit_clks) @(posedge clk);
      // brk keeps the line at space to show a break
      line_out <= ~brk;
      repeat (bit_clks) @(posedge clk);
   endtask
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
   import ascp_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   ascp_wb_req_t wb_req = '0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic rxd;
   logic txd;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   int nb;
   logic [31:0] rd;
   logic chr, st2, mp, pe, od, multiproc_flag_bit;
   logic [7:0] m, d1, d2, dr;

   always #10 clk = ~clk;

   ascp_core u_ascp_core (.clk(clk), .rst_b(rst_b), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .rxd(rxd), .txd(txd));
   ascp_peer u_ascp_peer (.clk(clk), .line_in(txd), .line_out(rxd));

   task conclude;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task bus(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      @(posedge clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: {24'h0, d}};
      do @(posedge clk);
      while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_req <= '0;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask

   task rdc(input string nm, input logic [7:0] a, input logic [7:0] mk, input logic [7:0] exp);
      bus(1'b0, a, 8'h00, 4'hf);
      check(nm, {24'h0, exp}, rd & {24'hffffff, mk});
   endtask

   task cfg(input int b, input int n, input logic x, input int s);
      u_ascp_peer.bit_clks = b;
      u_ascp_peer.nbits = n;
      u_ascp_peer.has_extra = x;
      u_ascp_peer.stops = s;
      u_ascp_peer.q.delete();
   endtask

   task wait_q(input int n);
      while (u_ascp_peer.q.size() < n) @(posedge clk);
   endtask

   function automatic logic xb(input logic [7:0] d);
      return mp ? multiproc_flag_bit : od ^ (^(d & m));
   endfunction

   always @(posedge clk) begin
      cycles <= cycles + 1;
      // sized for about 40k cycles of traffic
      if (cycles == 100000) begin
         failures++;
         conclude;
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      rdc("mode", ASCP_OFS_MODE, 8'hff, ASCP_MODE_RST);
      rdc("div", ASCP_OFS_DIV, 8'hff, ASCP_DIV_RST);
      rdc("ctrl", ASCP_OFS_CTRL, 8'hff, ASCP_CTRL_RST);
      rdc("status", ASCP_OFS_STATUS, 8'hff, 8'h84);
      rdc("unmapped", 8'h18, 8'hff, 8'h00);
      bus(1'b1, ASCP_OFS_DIV, 8'h12, 4'he);
      wr(8'h18, 8'h5a);
      rdc("div kept", ASCP_OFS_DIV, 8'hff, 8'hff);
      rdc("mode kept", ASCP_OFS_MODE, 8'hff, 8'h00);
      for (int f = 0; f < 16; f++) begin
         chr = f[0];
         st2 = f[1];
         mp = (f[3:2] == 2'd3);
         pe = f[3] | f[2];
         od = f[3] & ~f[2];
         multiproc_flag_bit = f[0];
         m = chr ? 8'h7f : 8'hff;
         nb = chr ? 7 : 8;
         d1 = 8'ha5 ^ 8'(f);
         d2 = 8'h3c + 8'(f);
         dr = ~d1;
         wr(ASCP_OFS_CTRL, 8'h00);
         wr(ASCP_OFS_MODE, {1'b0, chr, pe, od, st2, mp, 2'b00});
         wr(ASCP_OFS_DIV, 8'h00);
         cfg(32, nb, pe, st2 ? 2 : 1);
         wr(ASCP_OFS_CTRL, 8'h30 | {7'h0, multiproc_flag_bit});
         fork
            begin
               wr(ASCP_OFS_TXDATA, d1);
               do bus(1'b0, ASCP_OFS_STATUS, 8'h00, 4'hf);
               while (rd[7] !== 1'b1);
               wr(ASCP_OFS_TXDATA, d2);
            end
            u_ascp_peer.send(dr, xb(dr), 1'b1, 1'b0);
         join
         wait_q(2);
         check("tx a", {1'b1, pe & xb(d1), d1 & m}, u_ascp_peer.q[0]);
         check("tx b", {1'b1, pe & xb(d2), d2 & m}, u_ascp_peer.q[1]);
         // first start bit may lose one clock to the free-running tick phase
         check("gap", (2 + nb + pe + st2) * 16, (u_ascp_peer.last_gap + 1) / 2);
         rdc("rx status", ASCP_OFS_STATUS, 8'hf8, 8'hc0);
         if (mp) rdc("rx flag", ASCP_OFS_STATUS, 8'h02, {6'h0, multiproc_flag_bit, 1'b0});
         rdc("rx data", ASCP_OFS_RXDATA, 8'hff, dr & m);
         wr(ASCP_OFS_STATUS, 8'hbf);
      end
      wr(ASCP_OFS_CTRL, 8'h00);
      wr(ASCP_OFS_MODE, 8'h20);
      cfg(32, 8, 1'b1, 1);
      wr(ASCP_OFS_CTRL, 8'h30);
      u_ascp_peer.send(8'h11, 1'b1, 1'b1, 1'b0);
      rdc("parity err", ASCP_OFS_STATUS, 8'h78, 8'h48);
      rdc("parity data", ASCP_OFS_RXDATA, 8'hff, 8'h11);
      wr(ASCP_OFS_STATUS, 8'h87);
      u_ascp_peer.send(8'h00, 1'b0, 1'b0, 1'b1);
      rdc("framing err", ASCP_OFS_STATUS, 8'h79, 8'h51);
      u_ascp_peer.line_out <= 1'b1;
      repeat (40) @(posedge clk);
      rdc("break end", ASCP_OFS_STATUS, 8'h01, 8'h00);
      wr(ASCP_OFS_STATUS, 8'h87);
      u_ascp_peer.send(8'h21, 1'b0, 1'b1, 1'b0);
      u_ascp_peer.send(8'h42, 1'b0, 1'b1, 1'b0);
      rdc("overrun", ASCP_OFS_STATUS, 8'h78, 8'h60);
      rdc("overrun data", ASCP_OFS_RXDATA, 8'hff, 8'h21);
      wr(ASCP_OFS_CTRL, 8'h20);
      rdc("re off flags", ASCP_OFS_STATUS, 8'h78, 8'h60);
      rdc("re off data", ASCP_OFS_RXDATA, 8'hff, 8'h21);
      wr(ASCP_OFS_STATUS, 8'h87);
      wr(ASCP_OFS_TXDATA, 8'h00);
      repeat (100) @(posedge clk);
      wr(ASCP_OFS_CTRL, 8'h00);
      rdc("te off empty", ASCP_OFS_STATUS, 8'h80, 8'h80);
      repeat (60) @(posedge clk);
      check("te off line", 32'h1, {31'h0, txd});
      repeat (400) @(posedge clk);
      for (int n = 0; n < 4; n++) begin
         wr(ASCP_OFS_MODE, {6'h0, 2'(n)});
         wr(ASCP_OFS_DIV, (n == 0) ? 8'h02 : 8'h00);
         cfg(32 * (4 ** n) * ((n == 0) ? 3 : 1), 8, 1'b0, 1);
         wr(ASCP_OFS_CTRL, 8'h20);
         wr(ASCP_OFS_TXDATA, 8'hc3 ^ 8'(n));
         wait_q(1);
         check("rate", {2'b10, 8'hc3 ^ 8'(n)}, u_ascp_peer.q[0]);
         wr(ASCP_OFS_CTRL, 8'h00);
      end
      conclude;
   end
endmodule
